// [sar_consts.svh]
// Timing counts, widths and field constants for the converter control block.
// Assumes the block runs from a single 25 MHz clock.
`ifndef SAR_CONSTS_SVH
`define SAR_CONSTS_SVH
`define CLK_PERIOD_NS      40
`define SAMPLE_CLOCKS      32
`define ABORT_LIMIT        64
`define EOC_CLOCKS         8
`define EOC_EXTRA_NS       2000
`define EOC_EXTRA_CYC      (`EOC_EXTRA_NS / `CLK_PERIOD_NS)
`define DATA_W             8
`define CHAN_W             3
`define NUM_CHAN           8
`define RESULT_RESET       8'h00
`define RESULT_ALL_ONES    8'hff
`define MSB_WEIGHT         8'h80
`define CNT_W              7
`define PHASE_W            2
`define DECIDE_PHASE       2
`endif

// [sar_pkg.sv]
// Types shared by the converter control files.
// Assumes sar_consts.svh is compiled alongside.
package sar_pkg;
  typedef enum logic [1:0] {
    ST_IDLE,
    ST_SAMPLE,
    ST_CONVERT,
    ST_DONE
  } sar_state_t;
endpackage

// [sync2.sv]
// Two flip-flop synchroniser for pins from outside the clock domain.
// Assumes the destination clock is i_mclk.
module sync2 (
  input  wire logic i_mclk,
  input  wire logic i_rst,
  input  wire logic i_d,
  output logic      o_q
);
  logic meta_r;

  // The first stage feeds only the second stage.
  always_ff @(posedge i_mclk) begin
    if (i_rst) begin
      meta_r <= 1'b0;
      o_q    <= 1'b0;
    end else begin
      meta_r <= i_d;
      o_q    <= meta_r;
    end
  end
endmodule

// [chan_latch.sv]
// Channel address latch and one-hot decoder for the analog multiplexer.
// Assumes synchronised strobe and address inputs on i_mclk.
`include "sar_consts.svh"
module chan_latch (
  input  wire logic                   i_mclk,
  input  wire logic                   i_rst,
  input  wire logic                   i_strobe,
  input  wire logic [`CHAN_W-1:0]     i_addr,
  output logic      [`CHAN_W-1:0]     o_chan,
  output logic      [`NUM_CHAN-1:0]   o_select
);
  logic               strobe_d_r;
  logic [`CHAN_W-1:0] chan_nxt;

  // Capture only on a low-to-high strobe transition, hold otherwise.
  always_comb begin
    chan_nxt = o_chan;
    if (i_strobe && !strobe_d_r) begin
      chan_nxt = i_addr;
    end
  end

  always_ff @(posedge i_mclk) begin
    if (i_rst) begin
      strobe_d_r <= 1'b0;
      o_chan     <= '0;
      o_select   <= '0;
    end else begin
      strobe_d_r <= i_strobe;
      o_chan     <= chan_nxt;
      // Plain binary, MSB select bit first; exactly one channel routed.
      o_select   <= `NUM_CHAN'(1) << chan_nxt;
    end
  end
endmodule

// [mux_sar_adc_control.sv]
// Control logic of an eight-channel, eight-bit successive-approximation converter.
// Assumes an external comparator and capacitor array; pins arrive asynchronously.
// Function
// - Route exactly one of eight inputs, chosen by the latched channel code.
// - Select bits decode as plain binary channel number, MSB first.
// - Capture select bits only on rising edge of the channel latch strobe.
// - Start rising edge clears the output result latch.
// - Sampling begins at start edge and lasts 32 clock periods.
// - New start before the 64th clock aborts and restarts, discarding result.
// - A full conversion takes between 90 and 116 microseconds nominally; here 58 clocks from synchronised start edge to end flag, 2.32 us at 25 MHz.
// - End-of-conversion responds within 8 clock periods plus 2 microseconds.
// - Inputs at or above upper reference give all ones; below lower give zeros.
// - First decision tests weight 128 alone on the upper reference.
// - Above trip sets the bit and drops the weight; else weight stays up.
// - Remaining weights tested in strictly descending order to the LSB.
// - Exactly eight decisions per conversion, then idle until the next start edge.
// - Result outputs drive the bus only while output enable is asserted.
`include "sar_consts.svh"
module mux_sar_adc_control (
  input  wire logic                   i_mclk,
  input  wire logic                   i_rst,
  input  wire logic [`CHAN_W-1:0]     i_addr,
  input  wire logic                   i_channel_latch_strobe,
  input  wire logic                   i_start,
  input  wire logic                   i_output_enable,
  input  wire logic                   i_comp_above,
  output logic      [`CHAN_W-1:0]     o_chan,
  output logic      [`NUM_CHAN-1:0]   o_chan_select,
  output logic                        o_sample,
  output logic      [`DATA_W-1:0]     o_weights_up,
  output logic                        o_eoc,
  output logic      [`DATA_W-1:0]     o_data,
  output logic      [`DATA_W-1:0]     o_data_oe_n
);
  logic                  start_s;
  logic                  oe_s;
  logic                  comp_s;
  logic                  strobe_s;
  logic [`CHAN_W-1:0]    addr_s;
  logic                  start_d_r;
  logic                  start_rise;

  sar_pkg::sar_state_t   state_r;
  sar_pkg::sar_state_t   state_nxt;
  logic [`CNT_W-1:0]     cnt_r;
  logic [`CNT_W-1:0]     cnt_nxt;
  logic [`DATA_W-1:0]    trial_r;
  logic [`DATA_W-1:0]    trial_nxt;
  logic [`DATA_W-1:0]    sar_r;
  logic [`DATA_W-1:0]    sar_nxt;
  logic [`DATA_W-1:0]    up_r;
  logic [`DATA_W-1:0]    up_nxt;
  logic [`DATA_W-1:0]    result_r;
  logic [`DATA_W-1:0]    result_nxt;
  logic                  eoc_r;
  logic                  eoc_nxt;
  logic [`PHASE_W-1:0]   phase_r;
  logic [`PHASE_W-1:0]   phase_nxt;

  // Every pin from the outside world except i_rst is synchronised before use.
  sync2 u_sync_start (
    .i_mclk (i_mclk),
    .i_rst  (i_rst),
    .i_d    (i_start),
    .o_q    (start_s)
  );
  sync2 u_sync_oe (
    .i_mclk (i_mclk),
    .i_rst  (i_rst),
    .i_d    (i_output_enable),
    .o_q    (oe_s)
  );
  sync2 u_sync_comp (
    .i_mclk (i_mclk),
    .i_rst  (i_rst),
    .i_d    (i_comp_above),
    .o_q    (comp_s)
  );
  sync2 u_sync_strobe (
    .i_mclk (i_mclk),
    .i_rst  (i_rst),
    .i_d    (i_channel_latch_strobe),
    .o_q    (strobe_s)
  );

  genvar g;
  generate
    for (g = 0; g < `CHAN_W; g++) begin : g_addr_sync
      sync2 u_sync_addr (
        .i_mclk (i_mclk),
        .i_rst  (i_rst),
        .i_d    (i_addr[g]),
        .o_q    (addr_s[g])
      );
    end
  endgenerate

  // Address passes the same two stages as the strobe, so they stay aligned.
  chan_latch u_chan (
    .i_mclk   (i_mclk),
    .i_rst    (i_rst),
    .i_strobe (strobe_s),
    .i_addr   (addr_s),
    .o_chan   (o_chan),
    .o_select (o_chan_select)
  );

  assign start_rise = start_s && !start_d_r;

  // Sequencer: sampling for a fixed count, then one decision per weight,
  // each decision using three clocks (settle, cross, decide) so that the
  // comparator answer to the new weights has crossed both synchroniser
  // stages before it is read; two clocks would decide on a stale answer.
  always_comb begin
    state_nxt  = state_r;
    cnt_nxt    = cnt_r;
    trial_nxt  = trial_r;
    sar_nxt    = sar_r;
    up_nxt     = up_r;
    result_nxt = result_r;
    eoc_nxt    = eoc_r;
    phase_nxt  = phase_r;
    if (start_rise) begin
      // A start edge always restarts; an unfinished result is dropped.
      state_nxt  = sar_pkg::ST_SAMPLE;
      cnt_nxt    = '0;
      sar_nxt    = `RESULT_RESET;
      result_nxt = `RESULT_RESET;
      eoc_nxt    = 1'b0;
      up_nxt     = '0;
      trial_nxt  = '0;
      phase_nxt  = '0;
    end else begin
      case (state_r)
        sar_pkg::ST_IDLE: begin
          state_nxt = sar_pkg::ST_IDLE;
        end
        sar_pkg::ST_SAMPLE: begin
          cnt_nxt = cnt_r + `CNT_W'(1);
          if (cnt_r == `CNT_W'(`SAMPLE_CLOCKS - 1)) begin
            state_nxt = sar_pkg::ST_CONVERT;
            trial_nxt = `MSB_WEIGHT;
            up_nxt    = `MSB_WEIGHT;
            phase_nxt = '0;
          end
        end
        sar_pkg::ST_CONVERT: begin
          cnt_nxt   = cnt_r + `CNT_W'(1);
          phase_nxt = phase_r + `PHASE_W'(1);
          if (phase_r == `PHASE_W'(`DECIDE_PHASE)) begin
            phase_nxt = '0;
            if (comp_s) begin
              // Above trip: keep the bit, return the weight low.
              sar_nxt = sar_r | trial_r;
              up_nxt  = up_r & ~trial_r;
            end
            // Next lower weight goes up for its own test.
            trial_nxt = trial_r >> 1;
            up_nxt    = (comp_s ? (up_r & ~trial_r) : up_r) | (trial_r >> 1);
            if (trial_r[0]) begin
              state_nxt = sar_pkg::ST_DONE;
            end
          end
        end
        sar_pkg::ST_DONE: begin
          // All eight bits transfer to the output latch on the same edge the flag rises.
          result_nxt = sar_r;
          eoc_nxt    = 1'b1;
          state_nxt  = sar_pkg::ST_IDLE;
          up_nxt     = '0;
          cnt_nxt    = '0;
        end
        default: begin
          state_nxt = sar_pkg::ST_IDLE;
        end
      endcase
    end
  end

  always_ff @(posedge i_mclk) begin
    if (i_rst) begin
      start_d_r <= 1'b0;
      state_r   <= sar_pkg::ST_IDLE;
      cnt_r     <= '0;
      trial_r   <= '0;
      sar_r     <= `RESULT_RESET;
      up_r      <= '0;
      result_r  <= `RESULT_RESET;
      eoc_r     <= 1'b0;
      phase_r   <= '0;
    end else begin
      start_d_r <= start_s;
      state_r   <= state_nxt;
      cnt_r     <= cnt_nxt;
      trial_r   <= trial_nxt;
      sar_r     <= sar_nxt;
      up_r      <= up_nxt;
      result_r  <= result_nxt;
      eoc_r     <= eoc_nxt;
      phase_r   <= phase_nxt;
    end
  end

  // Outputs; data lines are released unless output enable is high.
  assign o_sample     = (state_r == sar_pkg::ST_SAMPLE);
  assign o_weights_up = up_r;
  assign o_eoc        = eoc_r;
  assign o_data       = result_r;
  assign o_data_oe_n  = {`DATA_W{~oe_s}};
endmodule

// [mux_sar_sva.sv]
// Port checker for the converter control block.
// Assumes one clock and the widths of sar_consts.svh.
`include "sar_consts.svh"
module mux_sar_sva (
  input wire logic                 i_mclk,
  input wire logic                 i_rst,
  input wire logic                 i_start,
  input wire logic                 i_output_enable,
  input wire logic [`CHAN_W-1:0]   o_chan,
  input wire logic [`NUM_CHAN-1:0] o_chan_select,
  input wire logic                 o_sample,
  input wire logic [`DATA_W-1:0]   o_weights_up,
  input wire logic                 o_eoc,
  input wire logic [`DATA_W-1:0]   o_data,
  input wire logic [`DATA_W-1:0]   o_data_oe_n
);
  logic [6:0] scnt_r;
  logic [6:0] scnt_nxt;
  // Counts unbroken sample clocks; reset folds in here so the flop only registers.
  always_comb scnt_nxt = (i_rst || !o_sample) ? 7'h00 : scnt_r + 7'h01;
  always_ff @(posedge i_mclk) scnt_r <= scnt_nxt;
  default clocking cb @(posedge i_mclk); endclocking
  default disable iff (i_rst);
  a_sel_decode: assert property (
    $changed(o_chan) |-> ##[0:1] o_chan_select == (8'h01 << o_chan))
    else $error("channel select not one-hot of channel");
  a_oe_on: assert property (
    $rose(i_output_enable) |-> ##[1:4] o_data_oe_n == 8'h00)
    else $error("data not driven after enable");
  a_oe_off: assert property (
    $fell(i_output_enable) |-> ##[1:4] o_data_oe_n == 8'hff)
    else $error("data still driven after enable off");
  a_eoc_drop: assert property (
    $rose(i_start) |-> ##[1:4] !o_eoc)
    else $error("end flag did not drop after start");
  a_data_clear: assert property (
    $fell(o_eoc) |-> o_data == 8'h00)
    else $error("result not cleared at start");
  a_sample_len: assert property (
    $fell(o_sample) |-> scnt_r == 7'h20)
    else $error("sample phase length wrong");
  a_msb_first: assert property (
    $fell(o_sample) |-> o_weights_up == 8'h80)
    else $error("first test is not the top weight");
  a_conv_done: assert property (
    $fell(o_sample) |-> ##[1:26] (o_eoc || o_sample))
    else $error("bit phase did not finish");
  a_data_hold: assert property (
    o_eoc && $past(o_eoc) |-> $stable(o_data))
    else $error("result moved while end flag high");
  c_done: cover property ($rose(o_eoc));
  c_convert: cover property ($fell(o_sample));
  c_abort: cover property ($rose(i_start) && !o_eoc && !o_sample);
endmodule
bind mux_sar_adc_control mux_sar_sva u_mux_sar_sva (.i_mclk, .i_rst, .i_start,
  .i_output_enable, .o_chan, .o_chan_select, .o_sample, .o_weights_up, .o_eoc,
  .o_data, .o_data_oe_n);

// [comp_model.sv]
// Comparator model standing behind the capacitor array.
// Assumes kept weights return to the lower reference and rejected weights stay up.
module comp_model (
  input  wire logic [7:0] i_weights_up,
  input  wire logic [7:0] i_level,
  output logic            o_above
);
  logic [7:0] cur;
  logic [7:0] trial;
  // Lowest raised weight is the one under test; it answers at once.
  always_comb begin
    cur = i_weights_up & (~i_weights_up + 8'h01);
    trial = (~i_weights_up & ~(cur | (cur - 8'h01))) | cur;
    o_above = (cur != 8'h00) && (i_level >= trial);
  end
endmodule

// [test_mux_sar_adc_control.sv]
// Self-checking bench for the converter control block.
// Assumes comp_model and the bound checker are compiled first.
module test_mux_sar_adc_control;
  timeunit 1ns;
  timeprecision 1ns;
  logic       i_mclk = 1'b0, i_rst = 1'b1, i_start = 1'b0, i_output_enable = 1'b0;
  logic       i_channel_latch_strobe = 1'b0, i_comp_above;
  logic [2:0] i_addr = 3'h0, o_chan;
  logic [7:0] o_chan_select, o_weights_up, o_data, o_data_oe_n, level = 8'h00;
  logic       o_sample, o_eoc;
  logic [31:0] seed = 32'h0001_060c;
  int         miscompares = 0, check_count = 0, exp_q[$];
  int         runs = 0;
  logic       eoc_seen = 1'b0;
  mux_sar_adc_control u_mux_sar_adc_control (.i_mclk, .i_rst, .i_addr,
    .i_channel_latch_strobe, .i_start, .i_output_enable, .i_comp_above, .o_chan,
    .o_chan_select, .o_sample, .o_weights_up, .o_eoc, .o_data, .o_data_oe_n);
  comp_model u_comp_model (.i_weights_up(o_weights_up), .i_level(level),
    .o_above(i_comp_above));
  // Free-running clock at 25 MHz.
  initial forever #20 i_mclk = ~i_mclk;
  function automatic logic [7:0] xs();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed[7:0];
  endfunction
  task automatic tick(int n);
    repeat (n) @(posedge i_mclk);
  endtask
  task automatic chk(string n, logic [7:0] e, logic [7:0] g);
    check_count++;
    if (g !== e) begin
      miscompares++;
      $display("Error %s expected %h seen %h", n, e, g);
    end
  endtask
  task automatic give_verdict();
    $display("checks %0d mismatches %0d", check_count, miscompares);
    if (miscompares == 0 && check_count > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask
  // Polls at the falling edge so register updates have landed.
  task automatic wait_eoc(logic v);
    int k;
    for (k = 0; k < 200 && o_eoc !== v; k++) @(negedge i_mclk);
    if (k == 200) begin
      miscompares++;
      give_verdict();
    end
  endtask
  // One start pulse; an abort replaces the pending expected result.
  task automatic start(logic [7:0] lv);
    tick(1);
    level <= lv;
    i_start <= 1'b1;
    tick(2);
    i_start <= 1'b0;
    exp_q = {int'(lv)};
  endtask
  task automatic conv(logic [7:0] lv);
    start(lv);
    wait_eoc(1'b0);
    chk("data cleared", 8'h00, o_data);
    wait_eoc(1'b1);
    chk("result", 8'(exp_q.pop_front()), o_data);
  endtask
  initial begin
    tick(6);
    i_rst <= 1'b0;
    tick(4);
    @(negedge i_mclk);
    chk("reset eoc", 8'h00, {7'h00, o_eoc});
    chk("reset oe_n", 8'hff, o_data_oe_n);
    // The address is moved after the strobe falls and must not be taken.
    for (int c = 0; c < 8; c++) begin
      tick(1);
      i_addr <= 3'(c);
      tick(3);
      i_channel_latch_strobe <= 1'b1;
      tick(4);
      i_channel_latch_strobe <= 1'b0;
      tick(4);
      i_addr <= ~3'(c);
      tick(6);
      @(negedge i_mclk);
      chk("chan", 8'(c), {5'h00, o_chan});
      chk("select", 8'h01 << c, o_chan_select);
    end
    $display("done: channel latch");
    conv(8'h00);
    conv(8'hff);
    conv(8'h80);
    conv(8'h7f);
    repeat (6) conv(xs());
    $display("done: conversions");
    start(8'h5a);
    tick(40);
    conv(8'ha5);
    $display("done: abort");
    // Free running: one outside pulse, then the end flag drives start.
    start(8'h33);
    wait_eoc(1'b0);
    for (int k = 0; k < 300; k++) begin
      @(posedge i_mclk);
      i_start <= o_eoc;
      if (o_eoc && !eoc_seen) begin
        runs++;
        chk("free run", 8'h33, o_data);
      end
      eoc_seen = o_eoc;
    end
    i_start <= 1'b0;
    chk("free runs", 8'h01, {7'h00, runs > 2});
    $display("done: free running");
    tick(1);
    i_output_enable <= 1'b1;
    tick(5);
    @(negedge i_mclk);
    chk("oe_n on", 8'h00, o_data_oe_n);
    tick(1);
    i_output_enable <= 1'b0;
    tick(5);
    @(negedge i_mclk);
    chk("oe_n off", 8'hff, o_data_oe_n);
    $display("done: output enable");
    give_verdict();
  end
endmodule
